// ### dv/testbench.sv
// self-checking bench for the main clock generation block
// assumes clock_gen_pkg, a 250 MHz clk_sys and reference clocks far slower than it
`timescale 1ns/1ps
module testbench import clock_gen_pkg::*;;
  logic        clk_sys = 1'b0, arst_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, irq, internal_osc_clock, cpu_clock, clock_out_pin_o, clock_out_pin_oe;
  logic [5:0]  option_bits = 6'h25;
  logic        halt_active = 1'b0, rc_clock_in = 1'b0, xtal_clock_in = 1'b0;
  logic        oscillator_input_pin = 1'b0, default_ext_clock_pin = 1'b0, rc_osc_enable;
  logic [7:0]  trim_value, q;
  logic [3:0]  xtal_range_enable, xre_rst, run_ref = 4'h0;
  int          error_cnt = 0, checked = 0, n_osc, n_cpu, n_pin, min_run, ref_ph = 0;

  main_clock_generation_control #(.STARTUP_CYCLES(8), .LOCK_CYCLES(16), .PER_W(10))
    u_main_clock_generation_control (.clk_sys(clk_sys), .arst_n(arst_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq(irq), .option_bits(option_bits), .halt_active(halt_active),
    .oscillator_input_pin(oscillator_input_pin), .default_ext_clock_pin(default_ext_clock_pin),
    .rc_clock_in(rc_clock_in), .xtal_clock_in(xtal_clock_in), .trim_value(trim_value),
    .xtal_range_enable(xtal_range_enable), .rc_osc_enable(rc_osc_enable),
    .internal_osc_clock(internal_osc_clock), .cpu_clock(cpu_clock),
    .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe(clock_out_pin_oe));

  // ===========================================================
  // clocks
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // reference clocks: 1 MHz, 1 MHz, 500 kHz, 2 MHz
  always @(posedge clk_sys) begin
    ref_ph                <= (ref_ph + 1) % 1000;
    rc_clock_in           <= run_ref[0] && (ref_ph % 250 < 125);
    oscillator_input_pin  <= run_ref[1] && (ref_ph % 250 < 125);
    default_ext_clock_pin <= run_ref[2] && (ref_ph % 500 < 250);
    xtal_clock_in         <= run_ref[3] && (ref_ph % 125 < 62);
  end

  // ===========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_sys);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic do_reset(input logic [5:0] opt, input logic [3:0] refs);
    run_ref <= refs;
    @(posedge clk_sys);
    arst_n      <= 1'b0;
    option_bits <= opt;
    repeat (5) @(posedge clk_sys);
    xre_rst = xtal_range_enable;
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic measure(input int cyc);
    logic po, pc, pp;
    int   run;
    n_osc = 0;
    n_cpu = 0;
    n_pin = 0;
    min_run = 1000000;
    run = -1;
    po = internal_osc_clock;
    pc = cpu_clock;
    pp = clock_out_pin_o;
    repeat (cyc) begin
      @(posedge clk_sys);
      if (internal_osc_clock && !po) n_osc++;
      if (cpu_clock && !pc) n_cpu++;
      if (clock_out_pin_o && !pp) n_pin++;
      if (cpu_clock !== pc) begin
        if (run >= 0 && run + 1 < min_run) min_run = run + 1;
        run = 0;
      end else if (run >= 0) run++;
      po = internal_osc_clock;
      pc = cpu_clock;
      pp = clock_out_pin_o;
    end
  endtask

  function automatic logic inr(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction

  // ===========================================================
  // scenarios
  task automatic t_regs();
    do_reset(6'h25, 4'h1);
    bus(0, OFS_MAIN_CLOCK_CONTROL, 8'h00);
    chk("ctrl reset", q, RST_MAIN_CLOCK_CONTROL);
    chk("oe reset", clock_out_pin_oe, 1'b0);
    bus(0, OFS_RC_OSCILLATOR_TRIM, 8'h00);
    chk("trim reset", q, 8'hFF);
    bus(1, OFS_RC_OSCILLATOR_TRIM, 8'h80);
    bus(0, OFS_RC_OSCILLATOR_TRIM, 8'h00);
    chk("trim rw", q, 8'h80);
    chk("trim out", trim_value, 8'h80);
    bus(1, OFS_MAIN_CLOCK_CONTROL, 8'h02);
    bus(0, OFS_MAIN_CLOCK_CONTROL, 8'h00);
    chk("ctrl rw", q, 8'h02);
    chk("oe on", clock_out_pin_oe, 1'b1);
    bus(1, 5'h14, 8'hFF);
    bus(0, 5'h14, 8'h00);
    chk("unmapped", q, 8'h00);
    bus(1, OFS_MAIN_CLOCK_CONTROL, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("oe off", clock_out_pin_oe, 1'b0);
  endtask

  task automatic t_src();
    logic [5:0] opt[4] = '{6'h25, 6'h20, 6'h00, 6'h21};
    logic [3:0] rf[4]  = '{4'h1, 4'h2, 4'h4, 4'h8};
    int         nom[4] = '{20, 20, 10, 40};
    for (int k = 0; k < 4; k++) begin
      do_reset(opt[k], rf[k]);
      chk("trim after reset", trim_value, 8'hFF);
      chk("rc enable", rc_osc_enable, k == 0);
      measure(5000);
      chk("osc edges", inr(n_osc, nom[k] - 2, nom[k] + 2), 1'b1);
    end
    for (int k = 1; k < 5; k++) begin
      do_reset(6'h20 + 6'(k), 4'h8);
      chk("xtal enable in reset", xre_rst, 4'h1 << (k - 1));
    end
  endtask

  task automatic t_pll(input logic [5:0] opt, input logic [3:0] refs, input int lo, hi);
    do_reset(opt, refs);
    bus(0, OFS_CLOCK_STATUS, 8'h00);
    chk("lock early", q[BIT_STAT_LOCKED], 1'b0);
    repeat (1000) @(posedge clk_sys);
    bus(0, OFS_CLOCK_STATUS, 8'h00);
    chk("lock late", q[BIT_STAT_LOCKED], 1'b1);
    measure(5000);
    chk("pll edges", inr(n_osc, lo, hi), 1'b1);
  endtask

  task automatic t_irq_halt();
    chk("irq masked", irq, 1'b0);
    bus(1, OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq unmasked", irq, 1'b1);
    bus(1, OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    halt_active <= 1'b1;
    repeat (20) @(posedge clk_sys);
    bus(0, OFS_CLOCK_STATUS, 8'h00);
    chk("halt stops", q[BIT_STAT_RUNNING], 1'b0);
    bus(0, OFS_IRQ_STATUS, 8'h00);
    chk("restart event", q, 8'h02);
    measure(1000);
    chk("halt no clock", n_osc, 0);
    halt_active <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus(0, OFS_CLOCK_STATUS, 8'h00);
    chk("wake unlocked", q[BIT_STAT_LOCKED], 1'b0);
    repeat (1000) @(posedge clk_sys);
    bus(0, OFS_CLOCK_STATUS, 8'h00);
    chk("wake locked", q[BIT_STAT_LOCKED], 1'b1);
    chk("irq relock", irq, 1'b1);
  endtask

  task automatic t_slow();
    do_reset(6'h21, 4'h8);
    bus(1, OFS_MAIN_CLOCK_CONTROL, 8'h03);
    repeat (4200) @(posedge clk_sys);
    measure(16000);
    chk("slow cpu edges", inr(n_cpu, 3, 5), 1'b1);
    chk("pin follows", inr(n_pin - n_cpu, -1, 1), 1'b1);
    fork
      measure(9000);
      begin
        repeat (1000) @(posedge clk_sys);
        bus(1, OFS_MAIN_CLOCK_CONTROL, 8'h00);
      end
    join
    chk("no runt", min_run >= 60, 1'b1);
    measure(2000);
    chk("fast cpu edges", inr(n_cpu - n_osc, -1, 1), 1'b1);
    chk("oe off", clock_out_pin_oe, 1'b0);
  endtask

  // ===========================================================
  // run control
  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #360us;
    error_cnt++;
    give_verdict();
  end

  initial begin
    t_regs();
    t_src();
    t_pll(6'h3D, 4'h1, 150, 180);
    t_irq_halt();
    t_pll(6'h30, 4'h2, 72, 88);
    t_slow();
    give_verdict();
  end
endmodule

// ### logic/clock_gen_pkg.sv
// package for the main clock generation block: register map, fields, options, timing
// assumes a 250 MHz system clock and a classic wishbone register bus
package clock_gen_pkg;

  // ===========================================================
  // clock and timing
  localparam int CLK_MHZ        = 250;
  localparam int T_STARTUP_NS   = 10000;
  localparam int T_LOCK_NS      = 20000;
  localparam int STARTUP_CYC    = (T_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYC       = (T_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_FACTOR_LO  = 4;
  localparam int PLL_FACTOR_HI  = 8;
  localparam int SLOW_DIV       = 32;

  // ===========================================================
  // register byte offsets
  localparam logic [4:0] OFS_MAIN_CLOCK_CONTROL = 5'h00;
  localparam logic [4:0] OFS_RC_OSCILLATOR_TRIM = 5'h04;
  localparam logic [4:0] OFS_CLOCK_STATUS       = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS         = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK           = 5'h10;

  // ===========================================================
  // reset values and field positions
  localparam logic [7:0] RST_MAIN_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_RC_OSCILLATOR_TRIM = 8'hFF;
  localparam logic [1:0] RST_IRQ                = 2'h0;
  localparam int         BIT_SLOW_MODE_SELECT   = 0;
  localparam int         BIT_CLOCK_OUTPUT_EN    = 1;
  localparam int         BIT_STAT_LOCKED        = 0;
  localparam int         BIT_STAT_RUNNING       = 1;
  localparam int         BIT_EV_LOCKED          = 0;
  localparam int         BIT_EV_RESTART         = 1;

  // ===========================================================
  // clock source option codes
  localparam logic [2:0] SRC_EXT   = 3'h0;
  localparam logic [2:0] SRC_XTAL0 = 3'h1;
  localparam logic [2:0] SRC_XTAL3 = 3'h4;
  localparam logic [2:0] SRC_RC    = 3'h5;

  typedef struct packed {
    logic       multi_osc_used;
    logic       pll_en;
    logic       pll_x8;
    logic [2:0] source;
  } opt_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic       clock_output_enable;
    logic       slow_mode_select;
  } ctrl_t;

  typedef enum logic [1:0] {PLL_OFF, PLL_START, PLL_RUN} pll_state_t;

endpackage

// ### logic/main_clock_generation_control.sv
// main clock generation: source select, x4/x8 multiplier, slow mode divider, trim, clock out
// assumes oscillator clocks arrive as levels far slower than clk_sys; options are static straps
`timescale 1ns/1ps

// Overview of operation
// - enabled multiplier turns 1 MHz RC or external clock into x4 or x8
// - multiplier enable and factor come from two option bits, not registers
// - multiplier off and RC chosen: oscillator clock is the RC clock
// - multiplier off and RC not chosen: oscillator clock is the crystal clock for crystal sources, else external clock
// - multiplier output held off for a startup delay after reset or wake
// - read-only lock flag rises when multiplier output is at frequency
// - control bit 1 drives the clock pin; zero frees the pin
// - control bit 0 selects cpu clock undivided or divided by 32
// - control register resets to zero
// - eight-bit trim register is read/write and resets to all ones
// - trim sets frequency monotonically, 00h fastest, FFh slowest
// - clock source chosen by option: external, four crystal ranges, or RC
// - crystal oscillators keep running during reset
// - without the multi-oscillator the external clock comes from the default pin
module main_clock_generation_control
  import clock_gen_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int LOCK_CYCLES    = LOCK_CYC,
  parameter int PER_W          = 10
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [4:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic            ack_o,
  output logic            irq,
  input  wire logic [5:0] option_bits,
  input  wire logic       halt_active,
  input  wire logic       oscillator_input_pin,
  input  wire logic       default_ext_clock_pin,
  input  wire logic       rc_clock_in,
  input  wire logic       xtal_clock_in,
  output logic      [7:0] trim_value,
  output logic      [3:0] xtal_range_enable,
  output logic            rc_osc_enable,
  output logic            internal_osc_clock,
  output logic            cpu_clock,
  output logic            clock_out_pin_o,
  output logic            clock_out_pin_oe
);

  // ===========================================================
  // reset and input synchronisers
  logic       rst_q1;
  logic       rst_n;
  logic [9:0] async_s1;
  logic [9:0] async_s2;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // no reset here so crystal enables hold through reset
  always_ff @(posedge clk_sys) begin
    async_s1 <= {option_bits, oscillator_input_pin, default_ext_clock_pin,
                 rc_clock_in, xtal_clock_in};
    async_s2 <= async_s1;
  end

  wire opt_t opt_live   = opt_t'(async_s2[9:4]);
  wire logic osc_pin_s  = async_s2[3];
  wire logic dflt_pin_s = async_s2[2];
  wire logic rc_s       = async_s2[1];
  wire logic xtal_s     = async_s2[0];

  // ===========================================================
  // option capture after reset release
  opt_t opt;
  logic opt_loaded;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opt        <= '0;
      opt_loaded <= 1'b0;
    end else if (!opt_loaded) begin
      opt        <= opt_live;
      opt_loaded <= 1'b1;
    end
  end

  wire logic src_is_rc   = (opt.source == SRC_RC);
  wire logic src_is_xtal = (opt.source >= SRC_XTAL0) && (opt.source <= SRC_XTAL3);
  wire logic ext_clk     = opt.multi_osc_used ? osc_pin_s : dflt_pin_s;
  wire logic pll_ref     = src_is_rc ? rc_s : ext_clk;

  // live option decode keeps crystals running in reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_xtal
      assign xtal_range_enable[gi] = (opt_live.source == SRC_XTAL0 + 3'(gi));
    end
  endgenerate
  assign rc_osc_enable = (opt.source == SRC_RC);

  // ===========================================================
  // multiplier model
  pll_state_t       pll_state;
  logic [15:0]      seq_cnt;
  logic             locked;
  logic             ref_q;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] ph_cnt;
  logic             pll_clk;

  wire logic             ref_rise  = pll_ref & ~ref_q;
  wire logic [PER_W-1:0] half_per  = opt.pll_x8 ? (period >> 4) : (period >> 3);
  wire logic             start_end = (seq_cnt == 16'(STARTUP_CYCLES - 1));
  wire logic             lock_end  = (seq_cnt == 16'(LOCK_CYCLES - 1));
  wire logic             pll_want  = opt_loaded & opt.pll_en & ~halt_active;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_state <= PLL_OFF;
      seq_cnt   <= '0;
      locked    <= 1'b0;
    end else if (!pll_want) begin
      pll_state <= PLL_OFF;
      seq_cnt   <= '0;
      locked    <= 1'b0;
    end else begin
      unique case (pll_state)
        PLL_OFF: begin
          pll_state <= PLL_START;
          seq_cnt   <= '0;
        end
        PLL_START: begin
          seq_cnt <= start_end ? '0 : seq_cnt + 16'h0001;
          if (start_end) begin
            pll_state <= PLL_RUN;
          end
        end
        PLL_RUN: begin
          if (!locked) begin
            seq_cnt <= seq_cnt + 16'h0001;
            locked <= lock_end;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_q   <= 1'b0;
      per_cnt <= '0;
      period  <= '0;
      ph_cnt  <= '0;
      pll_clk <= 1'b0;
    end else begin
      ref_q   <= pll_ref;
      per_cnt <= ref_rise ? PER_W'(1) : per_cnt + PER_W'(1);
      if (ref_rise) begin
        period <= per_cnt;
      end
      if (pll_state != PLL_RUN) begin
        ph_cnt  <= '0;
        pll_clk <= 1'b0;
      end else if (ph_cnt + PER_W'(1) >= half_per) begin
        ph_cnt  <= '0;
        pll_clk <= ~pll_clk;
      end else begin
        ph_cnt <= ph_cnt + PER_W'(1);
      end
    end
  end

  // ===========================================================
  // oscillator clock select and slow mode divider
  logic       osc_q;
  logic [4:0] div_cnt;
  logic       slow_active;
  ctrl_t      ctrl;

  wire logic osc_direct = src_is_rc ? rc_s : (src_is_xtal ? xtal_s : ext_clk);
  wire logic osc_sel    = opt.pll_en ? pll_clk : osc_direct;
  wire logic osc_rise   = osc_sel & ~osc_q;
  wire logic div_align  = osc_rise && (div_cnt == 5'h0F);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_q       <= 1'b0;
      div_cnt     <= '0;
      slow_active <= 1'b0;
      cpu_clock   <= 1'b0;
    end else begin
      osc_q <= osc_sel;
      if (osc_rise) begin
        div_cnt <= div_cnt + 5'h01;
      end
      // both clocks rise together here, so no short phase
      if (div_align) begin
        slow_active <= ctrl.slow_mode_select;
      end
      cpu_clock <= slow_active ? div_cnt[4] : osc_q;
    end
  end

  assign internal_osc_clock = osc_q;

  // ===========================================================
  // clock output pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_out_pin_o  <= 1'b0;
      clock_out_pin_oe <= 1'b0;
    end else begin
      clock_out_pin_o  <= cpu_clock;
      clock_out_pin_oe <= ctrl.clock_output_enable;
    end
  end

  // ===========================================================
  // wishbone slave and registers
  logic [7:0] trim;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic       locked_q;
  logic       running_q;

  wire logic req      = cyc_i & stb_i & ~ack_o;
  wire logic wr_lane0 = req & we_i & sel_i[0];
  wire logic wr_ctrl  = wr_lane0 && (adr_i == OFS_MAIN_CLOCK_CONTROL);
  wire logic wr_trim  = wr_lane0 && (adr_i == OFS_RC_OSCILLATOR_TRIM);
  wire logic wr_istat = wr_lane0 && (adr_i == OFS_IRQ_STATUS);
  wire logic wr_imask = wr_lane0 && (adr_i == OFS_IRQ_MASK);
  wire logic running  = (pll_state == PLL_RUN);
  wire logic [1:0] ev = {running_q & ~running, locked & ~locked_q};
  wire logic [7:0] stat_rd = {6'h00, running, locked};

  logic [7:0] rd_mux;
  assign rd_mux = (adr_i == OFS_MAIN_CLOCK_CONTROL) ? ctrl :
                  (adr_i == OFS_RC_OSCILLATOR_TRIM) ? trim :
                  (adr_i == OFS_CLOCK_STATUS)       ? stat_rd :
                  (adr_i == OFS_IRQ_STATUS)         ? {6'h00, irq_status} :
                  (adr_i == OFS_IRQ_MASK)           ? {6'h00, irq_mask} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_o      <= 1'b0;
      dat_o      <= '0;
      ctrl       <= ctrl_t'(RST_MAIN_CLOCK_CONTROL);
      trim       <= RST_RC_OSCILLATOR_TRIM;
      irq_status <= RST_IRQ;
      irq_mask   <= RST_IRQ;
      locked_q   <= 1'b0;
      running_q  <= 1'b0;
    end else begin
      ack_o     <= req;
      dat_o     <= req ? {24'h000000, rd_mux} : 32'h00000000;
      locked_q  <= locked;
      running_q <= running;
      if (wr_ctrl) begin
        ctrl <= ctrl_t'({6'h00, dat_i[1:0]});
      end
      if (wr_trim) begin
        trim <= dat_i[7:0];
      end
      if (wr_imask) begin
        irq_mask <= dat_i[1:0];
      end
      // set wins over write-one clear
      irq_status <= (irq_status & ~(wr_istat ? dat_i[1:0] : 2'h0)) | ev;
    end
  end

  assign trim_value = trim;
  assign irq        = |(irq_status & irq_mask);

  // ===========================================================
  // assertions
  property p_hold_off;
    @(posedge clk_sys) disable iff (!rst_n)
      (pll_state != PLL_RUN) |=> !pll_clk;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("pll clock during startup");

  property p_start_len;
    @(posedge clk_sys) disable iff (!rst_n)
      (pll_state == PLL_START && start_end && pll_want) |=> (pll_state == PLL_RUN);
  endproperty
  a_start_len: assert property (p_start_len) else $error("startup not ended on time");

  property p_lock_run;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(locked) |-> $past(pll_state == PLL_RUN) && $past(lock_end);
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("lock without run time");

  property p_opt_stable;
    @(posedge clk_sys) disable iff (!rst_n)
      opt_loaded |=> $stable(opt);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("options changed at run");

  property p_rc_direct;
    @(posedge clk_sys) disable iff (!rst_n)
      (opt_loaded && !opt.pll_en && src_is_rc) |=> (internal_osc_clock == $past(rc_s));
  endproperty
  a_rc_direct: assert property (p_rc_direct) else $error("rc clock not direct");

  property p_ext_direct;
    @(posedge clk_sys) disable iff (!rst_n)
      (opt_loaded && !opt.pll_en && opt.source == SRC_EXT)
        |=> (internal_osc_clock == $past(ext_clk));
  endproperty
  a_ext_direct: assert property (p_ext_direct) else $error("external clock not direct");

  property p_clk_out;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl |=> ##1 (clock_out_pin_oe == $past(dat_i[1], 2));
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock out enable wrong");

  property p_slow_high;
    @(posedge clk_sys) disable iff (!rst_n)
      (slow_active && $rose(cpu_clock) && $past(slow_active)) |-> cpu_clock [*8];
  endproperty
  a_slow_high: assert property (p_slow_high) else $error("slow clock phase short");

  property p_ctrl_reset;
    @(posedge clk_sys) $rose(rst_n) |-> (ctrl == 8'h00) && (trim == 8'hFF);
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("reset values wrong");

  property p_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  property p_fast_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      !slow_active |=> (cpu_clock == $past(internal_osc_clock));
  endproperty
  a_fast_follow: assert property (p_fast_follow) else $error("fast cpu clock wrong");

  property p_pin_copy;
    @(posedge clk_sys) disable iff (!rst_n)
      clock_out_pin_oe |=> (clock_out_pin_o == $past(cpu_clock));
  endproperty
  a_pin_copy: assert property (p_pin_copy) else $error("clock pin not cpu clock");

  property p_trim_write;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_trim |=> (trim_value == $past(dat_i[7:0]));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      ev[BIT_EV_LOCKED] |=> irq_status[BIT_EV_LOCKED];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("lock event lost");

  c_lock:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(locked));
  c_slow:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(slow_active));
  c_restart: cover property (@(posedge clk_sys) disable iff (!rst_n) ev[BIT_EV_RESTART]);
  c_irq:     cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));

endmodule
